// ===== verilog/lsi2c_pkg.sv
/*
 Constants for the antenna supply serial slave: register indices, field positions,
 reset values and the slave address layout.
 Assumes a single 20 MHz system clock with the serial lines sampled synchronously.
*/
// Summary of operation
// - write is start, chip address with direction 0, register address, data bytes.
// - each further written byte goes to the next register, pointer advancing.
// - write runs until stop; stop may follow any acknowledge.
// - slave acknowledges every byte received when addressed.
// - access may start at any register named by the register address byte.
// - after address ack send register; continue while master acknowledges low.
// - data registers read back the byte last written.
// - register 0x2 bits 0-3 select output voltage; bits 4-7 reserved zero.
// - control registers 0x2, 0x3, 0x4 clear to zero at reset.
// - register 0x3 bit 0 enables tone output, gated by tone input pin.
// - register 0x3 bit 1 selects low power mode, only with tone disabled; the bit is passed to the output as written, whatever bit 0 holds.
// - register 0x3 bit 2 picks tone pin as 22 kHz signal, else envelope.
// - register 0x4 bit 0 selects lower output current limit range.
// - register 0x4 bit 1 selects 2.5 A switch limit, else 4 A.
// - register 0x4 bit 2 disables pulsed output current limiting.
// - register 0x4 bit 3 selects 180 ms pulsed on-time, else 90 ms.
package lsi2c_pkg;
    localparam logic [7:0] REG_OUT_VOLT = 8'h02;
    localparam logic [7:0] REG_TONE_PWR = 8'h03;
    localparam logic [7:0] REG_CUR_LIM = 8'h04;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    localparam logic [7:0] OUT_VOLT_MASK = 8'h0F;
    localparam logic [7:0] TONE_PWR_MASK = 8'h07;
    localparam logic [7:0] CUR_LIM_MASK = 8'h0F;
    localparam int TONE_EN_BIT = 0;
    localparam int LOW_PWR_BIT = 1;
    localparam int TONE_SRC_BIT = 2;
    localparam int RANGE_BIT = 0;
    localparam int SW_LIM_BIT = 1;
    localparam int PULSE_DIS_BIT = 2;
    localparam int PULSE_TIME_BIT = 3;
    // upper six address bits arbitrary; the low one comes from the select pin
    localparam logic [5:0] CHIP_ADDR_HI = 6'h04;
    localparam logic [2:0] BIT_LAST = 3'h7;
endpackage

// ===== verilog/lsi2c_regs.sv
/*
 Serial slave and its three control registers for an antenna supply controller.
 Assumes scl and sda inputs already synchronous to i_clk, sampled far faster than the bus rate,
 with an external pull-up resolving the open-drain sda.
*/
`timescale 1ns/10ps
module lsi2c_regs (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_addr_sel,
    input wire logic i_tone_input_pin,
    output logic o_sda_out,
    output logic o_sda_oe,
    output logic [3:0] o_out_volt_sel,
    output logic o_tone_output_enable,
    output logic o_tone_gate,
    output logic o_low_power_select,
    output logic o_tone_input_source_select,
    output logic o_output_limit_range,
    output logic o_switch_current_limit_select,
    output logic o_pulsed_limit_disable,
    output logic o_pulse_time_long
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_REG, ST_WDATA, ST_RDATA, ST_ACK, ST_MACK
    } lsi2c_state_type;

    // read path: unmapped and status addresses return zero here
    function automatic logic [7:0] read_reg(input logic [7:0] idx, input logic [7:0] r2,
                                            input logic [7:0] r3, input logic [7:0] r4);
        unique case (idx)
            lsi2c_pkg::REG_OUT_VOLT: read_reg = r2;
            lsi2c_pkg::REG_TONE_PWR: read_reg = r3;
            lsi2c_pkg::REG_CUR_LIM: read_reg = r4;
            default: read_reg = 8'h00;
        endcase
    endfunction

    // control registers sit at consecutive addresses from the first one
    localparam int CTL_COUNT = int'(lsi2c_pkg::REG_CUR_LIM - lsi2c_pkg::REG_OUT_VOLT) + 1;

    // field bits per control register, by position in the bank
    function automatic logic [7:0] ctl_mask(input int idx);
        unique case (idx)
            0: ctl_mask = lsi2c_pkg::OUT_VOLT_MASK;
            1: ctl_mask = lsi2c_pkg::TONE_PWR_MASK;
            default: ctl_mask = lsi2c_pkg::CUR_LIM_MASK;
        endcase
    endfunction

    function automatic logic wr_hit(input logic [7:0] idx, input int pos);
        wr_hit = idx == (lsi2c_pkg::REG_OUT_VOLT + 8'(pos));
    endfunction

    lsi2c_state_type state, next_state, ret_state, next_ret_state;
    logic scl_d, sda_d, next_scl_d, next_sda_d;
    logic scl_rise, scl_fall, start_seen, stop_seen;
    logic [7:0] shreg, next_shreg;
    logic [2:0] bitcnt, next_bitcnt;
    // set by the first bit of a byte, so the fall right after start is no byte end
    logic got_bits, next_got_bits;
    logic byte_end;
    logic addr_match;
    logic [7:0] ptr, next_ptr;
    logic sda_oe, next_sda_oe;
    logic [7:0] rd_byte;
    logic wr_en;
    logic [7:0] wr_idx;
    logic [7:0] wr_data;
    logic [7:0] ctl_q [CTL_COUNT];
    logic [7:0] next_ctl [CTL_COUNT];
    logic [7:0] reg2, reg3, reg4;
    logic tone_gate, next_tone_gate;

    // one-cycle history of both lines; edges and bus conditions come from it
    always_comb begin
        next_scl_d = i_scl;
        next_sda_d = i_sda;
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            // idle-high values, so no false edge or start follows reset
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= next_scl_d;
            sda_d <= next_sda_d;
        end
    end

    assign scl_rise = i_scl & ~scl_d;
    assign scl_fall = ~i_scl & scl_d;
    assign start_seen = i_scl & scl_d & sda_d & ~i_sda;
    assign stop_seen = i_scl & scl_d & ~sda_d & i_sda;
    // bitcnt wraps to zero after the eighth rise; the next fall ends the byte
    assign byte_end = scl_fall & got_bits & (bitcnt == 3'h0);
    assign addr_match = shreg[7:1] == {lsi2c_pkg::CHIP_ADDR_HI, i_addr_sel};
    assign rd_byte = read_reg(ptr, reg2, reg3, reg4);

    // bus protocol: byte framing, pointer, acknowledge and read data drive
    always_comb begin
        next_state = state;
        next_ret_state = ret_state;
        next_shreg = shreg;
        next_bitcnt = bitcnt;
        next_got_bits = got_bits;
        next_ptr = ptr;
        next_sda_oe = sda_oe;
        wr_en = 1'b0;
        wr_idx = ptr;
        wr_data = shreg;
        if (start_seen) begin
            // repeated start tolerated though the master should stop first
            next_state = ST_ADDR;
            next_bitcnt = 3'h0;
            next_got_bits = 1'b0;
            next_sda_oe = 1'b0;
        end else if (stop_seen) begin
            next_state = ST_IDLE;
            next_bitcnt = 3'h0;
            next_got_bits = 1'b0;
            next_sda_oe = 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    next_sda_oe = 1'b0;
                end
                ST_ADDR, ST_REG, ST_WDATA: begin
                    if (scl_rise) begin
                        next_shreg = {shreg[6:0], i_sda};
                        next_bitcnt = bitcnt + 3'h1;
                        next_got_bits = 1'b1;
                    end
                    if (byte_end) begin
                        next_got_bits = 1'b0;
                    end
                    if (byte_end && state == ST_ADDR) begin
                        if (addr_match) begin
                            next_sda_oe = 1'b1;
                            next_ret_state = shreg[0] ? ST_RDATA : ST_REG;
                            next_state = ST_ACK;
                        end else begin
                            // not ours: silent until the next start
                            next_state = ST_IDLE;
                        end
                    end else if (byte_end && state == ST_REG) begin
                        next_ptr = shreg;
                        next_sda_oe = 1'b1;
                        next_ret_state = ST_WDATA;
                        next_state = ST_ACK;
                    end else if (byte_end) begin
                        // stored before the ack, so a stop right after keeps it
                        wr_en = 1'b1;
                        next_ptr = ptr + 8'h01;
                        next_sda_oe = 1'b1;
                        next_ret_state = ST_WDATA;
                        next_state = ST_ACK;
                    end
                end
                ST_ACK: begin
                    // ack held low through the ninth clock; on its fall released, or for a read driven with the first data bit
                    if (scl_fall) begin
                        next_bitcnt = 3'h0;
                        next_state = ret_state;
                        if (ret_state == ST_RDATA) begin
                            next_shreg = rd_byte;
                            next_sda_oe = ~rd_byte[7];
                            next_ptr = ptr + 8'h01;
                        end else begin
                            next_sda_oe = 1'b0;
                        end
                    end
                end
                ST_RDATA: begin
                    if (scl_fall) begin
                        if (bitcnt == lsi2c_pkg::BIT_LAST) begin
                            // let go for the master's acknowledge
                            next_sda_oe = 1'b0;
                            next_state = ST_MACK;
                        end else begin
                            next_shreg = {shreg[6:0], 1'b0};
                            next_sda_oe = ~shreg[6];
                            next_bitcnt = bitcnt + 3'h1;
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        next_ret_state = i_sda ? ST_IDLE : ST_RDATA;
                    end
                    if (scl_fall && ret_state == ST_RDATA) begin
                        next_bitcnt = 3'h0;
                        next_shreg = rd_byte;
                        next_sda_oe = ~rd_byte[7];
                        next_ptr = ptr + 8'h01;
                        next_state = ST_RDATA;
                    end else if (scl_fall) begin
                        next_state = ST_IDLE;
                    end
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state <= ST_IDLE;
            ret_state <= ST_IDLE;
            shreg <= 8'h00;
            bitcnt <= 3'h0;
            got_bits <= 1'b0;
            ptr <= 8'h00;
            sda_oe <= 1'b0;
        end else begin
            state <= next_state;
            ret_state <= next_ret_state;
            shreg <= next_shreg;
            bitcnt <= next_bitcnt;
            got_bits <= next_got_bits;
            ptr <= next_ptr;
            sda_oe <= next_sda_oe;
        end
    end

    // register bank; writes to unmapped addresses hit nothing and are dropped
    for (genvar g = 0; g < CTL_COUNT; g++) begin : g_ctl
        always_comb begin
            next_ctl[g] = ctl_q[g];
            if (wr_en && wr_hit(wr_idx, g)) begin
                // reserved bits stored as zero whatever the master sends
                next_ctl[g] = wr_data & ctl_mask(g);
            end
        end

        always_ff @(posedge i_clk) begin
            if (i_srst) begin
                ctl_q[g] <= lsi2c_pkg::RESET_VALUE;
            end else begin
                ctl_q[g] <= next_ctl[g];
            end
        end
    end

    assign reg2 = ctl_q[0];
    assign reg3 = ctl_q[1];
    assign reg4 = ctl_q[2];

    // tone gate: pin drives tone only while enabled
    always_comb begin
        next_tone_gate = reg3[lsi2c_pkg::TONE_EN_BIT] & i_tone_input_pin;
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            tone_gate <= 1'b0;
        end else begin
            tone_gate <= next_tone_gate;
        end
    end

    // open drain: the pin is only ever pulled low
    assign o_sda_out = 1'b0;
    assign o_sda_oe = sda_oe;
    assign o_out_volt_sel = reg2[3:0];
    assign o_tone_output_enable = reg3[lsi2c_pkg::TONE_EN_BIT];
    assign o_tone_gate = tone_gate;
    // low power is passed as written; pairing it with tone off is the master's duty
    assign o_low_power_select = reg3[lsi2c_pkg::LOW_PWR_BIT];
    assign o_tone_input_source_select = reg3[lsi2c_pkg::TONE_SRC_BIT];
    assign o_output_limit_range = reg4[lsi2c_pkg::RANGE_BIT];
    assign o_switch_current_limit_select = reg4[lsi2c_pkg::SW_LIM_BIT];
    assign o_pulsed_limit_disable = reg4[lsi2c_pkg::PULSE_DIS_BIT];
    assign o_pulse_time_long = reg4[lsi2c_pkg::PULSE_TIME_BIT];
endmodule // lsi2c_regs

// ===== verification/lsi2c_regs_checker.sv
/*
 Port checker for the antenna supply serial slave.
 Assumes binding onto lsi2c_regs, one clock, synchronous reset.
*/
`timescale 1ns/10ps
module lsi2c_regs_checker (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_tone_input_pin,
    input wire logic o_sda_out,
    input wire logic o_sda_oe,
    input wire logic [3:0] o_out_volt_sel,
    input wire logic o_tone_output_enable,
    input wire logic o_tone_gate,
    input wire logic o_low_power_select,
    input wire logic o_tone_input_source_select,
    input wire logic o_output_limit_range,
    input wire logic o_switch_current_limit_select,
    input wire logic o_pulsed_limit_disable,
    input wire logic o_pulse_time_long
);
    wire [10:0] ctl = {o_out_volt_sel, o_tone_output_enable, o_low_power_select,
        o_tone_input_source_select, o_output_limit_range, o_switch_current_limit_select,
        o_pulsed_limit_disable, o_pulse_time_long};
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    sequence stop_seen; i_scl && $past(i_scl) && i_sda && !$past(i_sda); endsequence
    sequence start_seen; i_scl && $past(i_scl) && !i_sda && $past(i_sda); endsequence
    sequence after_fall; $past(i_scl, 2) && !$past(i_scl); endsequence
    // reset itself is the antecedent here, so no disable
    a_reset_clears: assert property (disable iff (1'b0)
        i_srst |=> ctl == 11'h000 && !o_sda_oe) else $error("outputs not cleared by reset");
    a_drive_low: assert property (o_sda_out == 1'b0) else $error("data pin drives high");
    a_gate_follows: assert property (
        o_tone_gate == $past(o_tone_output_enable && i_tone_input_pin)) else $error("gate wrong");
    a_oe_timing: assert property (!$stable(o_sda_oe) |-> after_fall)
        else $error("data drive moved outside scl low");
    a_reg_timing: assert property (!$stable(ctl) |-> after_fall)
        else $error("register changed off byte end");
    a_oe_held: assert property ($rose(o_sda_oe) |-> o_sda_oe [*6])
        else $error("acknowledge released early");
    a_stop_quiet: assert property (stop_seen |-> !o_sda_oe [*8])
        else $error("drive after stop");
    a_start_quiet: assert property (start_seen |-> !o_sda_oe)
        else $error("drive at start");
endmodule // lsi2c_regs_checker
bind lsi2c_regs lsi2c_regs_checker chk (.*);

// ===== verification/lsi2c_master.sv
/*
 Bus master model: drives scl and its data pull-down.
 Assumes i_sda is the resolved, pulled-up data line.
*/
`timescale 1ns/10ps
module lsi2c_master (
    input wire logic i_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda
);
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    // five clocks a phase keeps each scl phase above the four-sample minimum
    task automatic hp;
        repeat (5) @(posedge i_clk);
        #1;
    endtask
    task automatic bit_io(input logic b, output logic r);
        o_sda = b;
        hp();
        o_scl = 1'b1;
        hp();
        r = i_sda;
        o_scl = 1'b0;
        hp();
    endtask
    task automatic start;
        o_sda = 1'b0;
        hp();
        o_scl = 1'b0;
        hp();
    endtask
    task automatic stop;
        o_sda = 1'b0;
        hp();
        o_scl = 1'b1;
        hp();
        o_sda = 1'b1;
        hp();
    endtask
    // msb first, then the ninth clock; 1 on the data line means released
    task automatic xfer(input logic [7:0] wd, input logic ak, output logic [7:0] rd,
        output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(wd[i], rd[i]);
        bit_io(ak, ack);
    endtask
endmodule // lsi2c_master

// ===== verification/tb_lsi2c_regs.sv
/*
 Self-checking bench for the serial slave and its control registers.
 Assumes the master model and the bound checker.
*/
`timescale 1ns/10ps
module tb_lsi2c_regs;
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic i_addr_sel = 1'b0;
    logic i_tone_input_pin = 1'b0;
    logic scl, m_sda, sda_out, sda_oe, ack, tone_output_enable, gate, low_power_select, src, rng, swl, pdis, ptl;
    logic [3:0] volt;
    logic [7:0] rd, d, p;
    logic [7:0] val [2:4];
    int num_errors = 0;
    int total_checks = 0;
    wire sda = m_sda & ~(sda_oe & ~sda_out);
    initial forever #25 i_clk = ~i_clk;
    lsi2c_regs uut (.i_clk(i_clk), .i_srst(i_srst), .i_scl(scl), .i_sda(sda),
        .i_addr_sel(i_addr_sel), .i_tone_input_pin(i_tone_input_pin), .o_sda_out(sda_out),
        .o_sda_oe(sda_oe), .o_out_volt_sel(volt), .o_tone_output_enable(tone_output_enable),
        .o_tone_gate(gate), .o_low_power_select(low_power_select), .o_tone_input_source_select(src),
        .o_output_limit_range(rng), .o_switch_current_limit_select(swl),
        .o_pulsed_limit_disable(pdis), .o_pulse_time_long(ptl));
    lsi2c_master mst (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda(m_sda));
    function automatic logic [7:0] seen_reg(input int a);
        case (a)
            2: return {4'h0, volt};
            3: return {5'h00, src, low_power_select, tone_output_enable};
            default: return {4'h0, ptl, pdis, swl, rng};
        endcase
    endfunction
    function automatic logic [7:0] stored(input int a, input logic [7:0] v);
        // reserved bits are kept as zero whatever the master sends
        if (a == 2) return v & lsi2c_pkg::OUT_VOLT_MASK;
        return v & ((a == 3) ? lsi2c_pkg::TONE_PWR_MASK : lsi2c_pkg::CUR_LIM_MASK);
    endfunction
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic do_reset;
        i_srst = 1'b1;
        repeat (3) @(posedge i_clk);
        #1 i_srst = 1'b0;
        for (int a = 2; a <= 4; a++) begin
            val[a] = 8'h00;
            check("reset", seen_reg(a), 8'h00);
        end
    endtask
    task automatic frame(input logic rw, input logic sel, input logic [7:0] exp);
        mst.start();
        mst.xfer({lsi2c_pkg::CHIP_ADDR_HI, sel, rw}, 1'b1, rd, ack);
        check("addr ack", {7'h00, ack}, exp);
    endtask
    initial begin
        repeat (60000) @(posedge i_clk);
        num_errors++;
        wrap_up();
    end
    initial begin
        void'($urandom(32'h554c13a7));
        do_reset();
        for (int it = 0; it < 6; it++) begin
            p = 8'h02 + 8'(it % 3);
            frame(1'b0, i_addr_sel, 8'h00);
            mst.xfer(p, 1'b1, rd, ack);
            for (int k = 0; k < 3; k++) begin
                d = (it == 0) ? 8'hFF : 8'($urandom());
                // reserved bits kept at zero, as the master must
                if (p + k <= 4) d = stored(p + k, d);
                if (p + k == 3 && d[0]) d[1] = 1'b0;
                mst.xfer(d, 1'b1, rd, ack);
                check("data ack", {7'h00, ack}, 8'h00);
                if (p + k <= 4) val[p + k] = d;
            end
            mst.stop();
            for (int a = 2; a <= 4; a++) begin
                check("outputs", seen_reg(a), val[a]);
            end
            frame(1'b0, i_addr_sel, 8'h00);
            mst.xfer(8'h02, 1'b1, rd, ack);
            mst.stop();
            frame(1'b1, i_addr_sel, 8'h00);
            for (int a = 2; a <= 5; a++) begin
                mst.xfer(8'hFF, a == 5, rd, ack);
                check("read", rd, (a < 5) ? val[a] : 8'h00);
            end
            mst.stop();
            frame(1'b0, ~i_addr_sel, 8'h01);
            mst.stop();
            i_tone_input_pin = 1'($urandom());
            repeat (2) @(posedge i_clk);
            #1 check("gate", {7'h00, gate}, {7'h00, val[3][0] & i_tone_input_pin});
            i_addr_sel = ~i_addr_sel;
        end
        do_reset();
        wrap_up();
    end
endmodule // tb_lsi2c_regs
